// File: hdl/wakeup_sfr_pkg.sv
// Constants, register offsets and carrier structs for the wakeup / index / flash address SFR bank.
// Assumes a nibble-wide core register port clocked by mclk at 125 MHz.
// Summary of operation
// - Speaker wakeup flag, bit 3 of control register, reads 1 after a speaker-pin wakeup.
// - Two-bit sensitivity field: 00 highest sensitivity, 01/10/11 levels two to four.
// - Control bit 0 enables speaker-pin wakeup; control register resets to zero.
// - Status bit 3 is read-only and returns the synchronised speaker pin level.
// - Status bit 2 enables both buzzer-pin and speaker-pin wakeup.
// - Status bit 1 switches the port A bit 0 level detector on or off.
// - Status bit 0 is the global interrupt enable; status resets to 0001.
// - Post-increment port accesses SRAM at the index, then adds one to the index.
// - Any write to the watchdog restart register clears the watchdog, if enabled by option.
// - Five nibble registers form a 19-bit flash byte address, lowest nibble first.
// - Data flash is read as bytes at the 19-bit address.
// - Reading the flash data register returns the low nibble of the addressed byte.
// - Plain index port accesses SRAM at the index and leaves the index unchanged.
package wakeup_sfr_pkg;

    // ***************************************************************
    // Register offsets
    // ***************************************************************
    localparam logic [4:0] OFF_WAKE_CTRL   = 5'h12;
    localparam logic [4:0] OFF_WAKE_STATUS = 5'h13;
    localparam logic [4:0] OFF_SRAM_PORT   = 5'h15;
    localparam logic [4:0] OFF_SRAM_INC    = 5'h16;
    localparam logic [4:0] OFF_WDOG        = 5'h17;
    localparam logic [4:0] OFF_FADDR0      = 5'h18;
    localparam logic [4:0] OFF_FADDR1      = 5'h19;
    localparam logic [4:0] OFF_FADDR2      = 5'h1A;
    localparam logic [4:0] OFF_FADDR3      = 5'h1B;
    localparam logic [4:0] OFF_FADDR4      = 5'h1C;
    localparam logic [4:0] OFF_FDATA       = 5'h1D;

    // ***************************************************************
    // Field positions, widths and reset values
    // ***************************************************************
    localparam int         BIT_FLAG        = 3;
    localparam int         BIT_WAKE_EN     = 0;
    localparam int         BIT_PIN_LEVEL   = 3;
    localparam int         BIT_BZ_EN       = 2;
    localparam int         BIT_DET_EN      = 1;
    localparam int         BIT_GINT_EN     = 0;
    localparam int         SRAM_AW         = 10;
    localparam int         SRAM_DEPTH      = 1024;
    localparam int         FADDR_W         = 19;
    localparam int         FADDR_NIB       = 5;
    localparam logic [3:0] CTRL_RESET      = 4'h0;
    localparam logic [3:0] STATUS_RESET    = 4'h1;
    localparam logic [3:0] NIB_ZERO        = 4'h0;
    localparam logic [SRAM_AW-1:0] IDX_ONE = 10'h001;
    localparam int         CFG_MSB         = 2;
    localparam int         SENS_MSB        = 2;
    localparam int         SENS_LSB        = 1;
    localparam int         TOP_NIB_MSB     = 2;
    localparam int         NIB_W           = 4;

    // Register port carrier
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [3:0] wdata;
    } sfr_req_s;

    // Wakeup controls toward the analog detector
    typedef struct packed {
        logic       speakerWakeupEnable;
        logic       buzzerSpeakerWakeupEnable;
        logic       levelDetectorEnable;
        logic [1:0] wakeupSensitivitySelect;
    } wake_ctrl_s;

endpackage

// File: hdl/wakeup_sfr_bank.sv
// Nibble SFR bank: speaker wakeup, global interrupt enable, indexed SRAM, watchdog restart, flash address.
// Assumes the core issues one-cycle rd/wr strobes; read data is registered on the next edge.
`timescale 1ns/1ns
module wakeup_sfr_bank
    import wakeup_sfr_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    input  wire sfr_req_s             req,
    output logic [3:0]                rdata,
    input  wire logic [SRAM_AW-1:0]   indexLoad,
    input  wire logic                 indexLoadEn,
    output logic [SRAM_AW-1:0]        sramIndexPointer,
    input  wire logic                 speakerOutputPin,
    input  wire logic                 speakerWakeEvent,
    input  wire logic                 watchdogOptionEn,
    output logic                      watchdogClear,
    output wake_ctrl_s                wakeCtrl,
    output logic                      globalInterruptEnable,
    output logic [FADDR_W-1:0]        flashAddress,
    input  wire logic [7:0]           flashByte,
    output logic [3:0]                flashWriteNibble
);

    // ***************************************************************
    // Decode and state
    // ***************************************************************
    logic                wrCtrl, wrStat, wrPort, wrInc, rdInc, rdPort;
    logic [3:0]          ctrl_q;
    logic [3:0]          stat_q;
    logic                pinMeta_q, pinSync_q;
    logic                evtMeta_q, evtSync_q;
    logic [SRAM_AW-1:0]  idx_q;
    logic [3:0]          sram [SRAM_DEPTH];
    logic [3:0]          faddr_q [FADDR_NIB];
    logic [3:0]          fdata_q;
    logic                wdog_q;

    function automatic logic hit(input sfr_req_s r, input logic [4:0] off);
        hit = r.addr == off;
    endfunction

    assign wrCtrl = req.wr && hit(req, OFF_WAKE_CTRL);
    assign wrStat = req.wr && hit(req, OFF_WAKE_STATUS);
    assign wrPort = req.wr && hit(req, OFF_SRAM_PORT);
    assign wrInc  = req.wr && hit(req, OFF_SRAM_INC);
    assign rdPort = req.rd && hit(req, OFF_SRAM_PORT);
    assign rdInc  = req.rd && hit(req, OFF_SRAM_INC);

    // Pin and event come from outside the clock domain: two flops first
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pinMeta_q <= 1'b0;
            pinSync_q <= 1'b0;
            evtMeta_q <= 1'b0;
            evtSync_q <= 1'b0;
        end else begin
            pinMeta_q <= speakerOutputPin;
            pinSync_q <= pinMeta_q;
            evtMeta_q <= speakerWakeEvent;
            evtSync_q <= evtMeta_q;
        end
    end

    // Wakeup control; a detected wakeup beats a software clear in the same cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            if (wrCtrl) begin
                ctrl_q[CFG_MSB:0] <= req.wdata[CFG_MSB:0];
                if (!req.wdata[BIT_FLAG]) begin
                    ctrl_q[BIT_FLAG] <= 1'b0;
                end
            end
            if (evtSync_q) begin
                ctrl_q[BIT_FLAG] <= 1'b1;
            end
        end
    end

    // Status register: bit 3 is the live pin, not stored
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stat_q <= STATUS_RESET;
        end else if (wrStat) begin
            stat_q <= {1'b0, req.wdata[CFG_MSB:0]};
        end
    end

    // ***************************************************************
    // Indexed SRAM
    // ***************************************************************
    // Index loads from the core's pointer nibbles take priority over increment
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            idx_q <= '0;
        end else if (indexLoadEn) begin
            idx_q <= indexLoad;
        end else if (wrInc || rdInc) begin
            idx_q <= idx_q + IDX_ONE;
        end
    end

    // Both ports address the same location; only the ++ port moves the index
    always_ff @(posedge mclk) begin
        if (wrPort || wrInc) begin
            sram[idx_q] <= req.wdata;
        end
    end

    // ***************************************************************
    // Flash address and data nibbles
    // ***************************************************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < FADDR_NIB; i++) begin
                faddr_q[i] <= NIB_ZERO;
            end
            fdata_q <= NIB_ZERO;
        end else if (req.wr) begin
            for (int i = 0; i < FADDR_NIB; i++) begin
                if (req.addr == OFF_FADDR0 + 5'(i)) begin
                    faddr_q[i] <= req.wdata;
                end
            end
            if (hit(req, OFF_FDATA)) begin
                fdata_q <= req.wdata;
            end
        end
    end

    // Top nibble only contributes three bits to the 19-bit address
    assign flashAddress = {faddr_q[FADDR_NIB-1][TOP_NIB_MSB:0], faddr_q[3], faddr_q[2],
                           faddr_q[1], faddr_q[0]};
    assign flashWriteNibble = fdata_q;

    // Watchdog restart pulse, suppressed when the option disables the timer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wdog_q <= 1'b0;
        end else begin
            wdog_q <= req.wr && hit(req, OFF_WDOG) && watchdogOptionEn;
        end
    end
    assign watchdogClear = wdog_q;

    // ***************************************************************
    // Read mux, registered
    // ***************************************************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= NIB_ZERO;
        end else if (req.rd) begin
            case (req.addr)
                OFF_WAKE_CTRL:   rdata <= ctrl_q;
                OFF_WAKE_STATUS: rdata <= {pinSync_q, stat_q[CFG_MSB:0]};
                OFF_SRAM_PORT,
                OFF_SRAM_INC:    rdata <= sram[idx_q];
                OFF_FADDR0,
                OFF_FADDR1,
                OFF_FADDR2,
                OFF_FADDR3,
                OFF_FADDR4:      rdata <= faddr_q[3'(req.addr - OFF_FADDR0)];
                OFF_FDATA:       rdata <= flashByte[3:0];
                default:         rdata <= NIB_ZERO;
            endcase
        end
    end

    assign sramIndexPointer = idx_q;
    assign globalInterruptEnable = stat_q[BIT_GINT_EN];
    assign wakeCtrl.speakerWakeupEnable = ctrl_q[BIT_WAKE_EN];
    assign wakeCtrl.wakeupSensitivitySelect = ctrl_q[SENS_MSB:SENS_LSB];
    assign wakeCtrl.buzzerSpeakerWakeupEnable = stat_q[BIT_BZ_EN];
    assign wakeCtrl.levelDetectorEnable = stat_q[BIT_DET_EN];

    // ***************************************************************
    // Checks
    // ***************************************************************
    sequence s_wakeEvt;
        evtSync_q;
    endsequence

    a_flag_sets: assert property (@(posedge mclk) disable iff (!rst_b)
        s_wakeEvt |=> ctrl_q[BIT_FLAG]) else $error("wakeup flag not set");
    a_flag_holds: assert property (@(posedge mclk) disable iff (!rst_b)
        ctrl_q[BIT_FLAG] && !(wrCtrl && !req.wdata[BIT_FLAG]) |=> ctrl_q[BIT_FLAG])
        else $error("wakeup flag dropped");
    a_ctrl_write: assert property (@(posedge mclk) disable iff (!rst_b)
        wrCtrl |=> wakeCtrl.speakerWakeupEnable == $past(req.wdata[BIT_WAKE_EN]))
        else $error("wake enable not written");
    a_sens_write: assert property (@(posedge mclk) disable iff (!rst_b)
        wrCtrl |=> wakeCtrl.wakeupSensitivitySelect == $past(req.wdata[SENS_MSB:SENS_LSB]))
        else $error("sensitivity not written");
    a_pin_read: assert property (@(posedge mclk) disable iff (!rst_b)
        req.rd && hit(req, OFF_WAKE_STATUS) |=> rdata[BIT_PIN_LEVEL] == $past(pinSync_q))
        else $error("pin level read wrong");
    a_stat_write: assert property (@(posedge mclk) disable iff (!rst_b)
        wrStat |=> globalInterruptEnable == $past(req.wdata[BIT_GINT_EN])
            && wakeCtrl.buzzerSpeakerWakeupEnable == $past(req.wdata[BIT_BZ_EN]))
        else $error("status write wrong");
    a_idx_inc: assert property (@(posedge mclk) disable iff (!rst_b)
        (rdInc || wrInc) && !indexLoadEn |=> idx_q == $past(idx_q) + IDX_ONE)
        else $error("index not advanced");
    a_idx_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        (rdPort || wrPort) && !indexLoadEn |=> $stable(idx_q))
        else $error("index moved on plain port");
    a_wdog_clear: assert property (@(posedge mclk) disable iff (!rst_b)
        req.wr && hit(req, OFF_WDOG) |=> watchdogClear == $past(watchdogOptionEn))
        else $error("watchdog clear wrong");
    a_fdata_read: assert property (@(posedge mclk) disable iff (!rst_b)
        req.rd && hit(req, OFF_FDATA) |=> rdata == $past(flashByte[3:0]))
        else $error("flash nibble read wrong");

    // ***************************************************************
    // Wakeup control checks
    // ***************************************************************
    // The first two watch the path from the raw detector input, so a broken
    // synchroniser or a lost set shows up even if the flag logic
    // itself looks sound. The detector must hold its event for at
    // least two clocks, or the two-flop stage may miss it.

    sequence s_evtIn;
        speakerWakeEvent ##1 speakerWakeEvent;
    endsequence

    sequence s_clearWr;
        wrCtrl && !req.wdata[BIT_FLAG];
    endsequence

    // Two-clock event reaches the flag after the synchroniser
    a_flag_path: assert property (@(posedge mclk) disable iff (!rst_b)
        s_evtIn |-> ##2 ctrl_q[BIT_FLAG])
        else $error("wakeup event did not reach flag");

    // Event stage is exactly two flops deep
    a_evt_sync: assert property (@(posedge mclk) disable iff (!rst_b)
        evtSync_q == $past(speakerWakeEvent, 2))
        else $error("event synchroniser depth wrong");

    // Writing 0 clears the flag when no event competes
    a_flag_clear: assert property (@(posedge mclk) disable iff (!rst_b)
        s_clearWr && !evtSync_q |=> !ctrl_q[BIT_FLAG])
        else $error("wakeup flag not cleared");

    // Software cannot set the flag by writing 1
    a_flag_no_set: assert property (@(posedge mclk) disable iff (!rst_b)
        !ctrl_q[BIT_FLAG] && !evtSync_q |=> !ctrl_q[BIT_FLAG])
        else $error("wakeup flag set without event");

    // Control holds while neither write nor event touches it
    a_ctrl_stable: assert property (@(posedge mclk) disable iff (!rst_b)
        !wrCtrl && !evtSync_q |=> $stable(ctrl_q))
        else $error("control register changed");

    // Control read returns the stored nibble, flag included
    a_ctrl_read: assert property (@(posedge mclk) disable iff (!rst_b)
        req.rd && hit(req, OFF_WAKE_CTRL) |=> rdata == $past(ctrl_q))
        else $error("control read wrong");

    // ***************************************************************
    // Status checks
    // ***************************************************************
    // Detector enable follows its written bit
    a_det_write: assert property (@(posedge mclk) disable iff (!rst_b)
        wrStat |=> wakeCtrl.levelDetectorEnable == $past(req.wdata[BIT_DET_EN]))
        else $error("detector enable not written");

    // Status holds between writes
    a_stat_stable: assert property (@(posedge mclk) disable iff (!rst_b)
        !wrStat |=> $stable(stat_q))
        else $error("status register changed");

    // Status read returns the stored enables below the pin bit
    a_stat_read: assert property (@(posedge mclk) disable iff (!rst_b)
        req.rd && hit(req, OFF_WAKE_STATUS) |=> rdata[CFG_MSB:0] == $past(stat_q[CFG_MSB:0]))
        else $error("status read wrong");

    // Pin stage is exactly two flops deep
    a_pin_sync: assert property (@(posedge mclk) disable iff (!rst_b)
        pinSync_q == $past(speakerOutputPin, 2))
        else $error("pin synchroniser depth wrong");

    // ***************************************************************
    // Index checks
    // ***************************************************************
    // A load from the core replaces the index
    a_idx_load: assert property (@(posedge mclk) disable iff (!rst_b)
        indexLoadEn |=> idx_q == $past(indexLoad))
        else $error("index not loaded");

    // Without load or post-increment access the index stays put
    a_idx_idle: assert property (@(posedge mclk) disable iff (!rst_b)
        !indexLoadEn && !rdInc && !wrInc |=> $stable(idx_q))
        else $error("index moved while idle");

    // ***************************************************************
    // Watchdog, flash and read port checks
    // ***************************************************************
    // No clear pulse without a restart write
    a_wdog_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
        !(req.wr && hit(req, OFF_WDOG)) |=> !watchdogClear)
        else $error("spurious watchdog clear");

    // Lowest nibble lands at the bottom of the address
    a_faddr_low: assert property (@(posedge mclk) disable iff (!rst_b)
        req.wr && hit(req, OFF_FADDR0) |=> flashAddress[NIB_W-1:0] == $past(req.wdata))
        else $error("address nibble 0 misplaced");

    // Second nibble lands just above the first
    a_faddr_mid: assert property (@(posedge mclk) disable iff (!rst_b)
        req.wr && hit(req, OFF_FADDR1) |=> flashAddress[2*NIB_W-1:NIB_W] == $past(req.wdata))
        else $error("address nibble 1 misplaced");

    // Only three bits of the top nibble reach the address
    a_faddr_top: assert property (@(posedge mclk) disable iff (!rst_b)
        req.wr && hit(req, OFF_FADDR4) |=> flashAddress[FADDR_W-1:FADDR_W-1-TOP_NIB_MSB]
            == $past(req.wdata[TOP_NIB_MSB:0]))
        else $error("top address nibble misplaced");

    // The top nibble still reads back all four stored bits
    a_faddr_rdback: assert property (@(posedge mclk) disable iff (!rst_b)
        req.rd && hit(req, OFF_FADDR4) |=> rdata == $past(faddr_q[FADDR_NIB-1]))
        else $error("top address nibble read wrong");

    // Address is steady without a write
    a_faddr_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        !req.wr |=> $stable(flashAddress))
        else $error("flash address changed");

    // Write nibble follows a data register write
    a_fdata_write: assert property (@(posedge mclk) disable iff (!rst_b)
        req.wr && hit(req, OFF_FDATA) |=> flashWriteNibble == $past(req.wdata))
        else $error("flash write nibble wrong");

    // Read data stands until the next read
    a_rd_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        !req.rd |=> $stable(rdata))
        else $error("read data changed");

endmodule

// File: testbench/far_side_model.sv
// Far side of the bank: speaker pin and wakeup detector, plus a data flash array.
// Assumes the bench steers pin level and detector events; flash bytes are a fixed address pattern.
`timescale 1ns/1ns
module far_side_model
    import wakeup_sfr_pkg::*;
(
    input  wire logic               pinLevel,
    input  wire logic               wakeReq,
    input  wire logic [FADDR_W-1:0] flashAddress,
    output logic                    speakerOutputPin,
    output logic                    speakerWakeEvent,
    output logic [7:0]              flashByte
);
    // ***************************************************************
    // Pin, detector and flash array
    // ***************************************************************
    // Pin level and detector event pass straight through; the bench holds events 3 cycles
    assign speakerOutputPin = pinLevel;
    assign speakerWakeEvent = wakeReq;
    // Address bits 7:0 and 18:11 reach the byte, bits 10:8 do not; each nibble still touches it, so a lost nibble shows up
    assign flashByte = flashAddress[7:0] ^ flashAddress[18:11] ^ 8'h5A;
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the wakeup / index / flash address register bank.
// Assumes the far side model on the pin and flash ports; reads are checked from a queue.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
    import wakeup_sfr_pkg::*;
    logic               mclk, rst_b, indexLoadEn, watchdogOptionEn, pinLevel, wakeReq;
    logic               watchdogClear, globalInterruptEnable, speakerOutputPin, speakerWakeEvent;
    logic               rdSeen;
    sfr_req_s           req;
    wake_ctrl_s         wakeCtrl;
    logic [3:0]         rdata, flashWriteNibble, v, expV;
    logic [3:0]         nib [4];
    logic [3:0]         expQ [$];
    logic [SRAM_AW-1:0] indexLoad, sramIndexPointer;
    logic [FADDR_W-1:0] flashAddress;
    logic [19:0]        fa;
    logic [7:0]         flashByte;
    int                 n_errors = 0, checks = 0, cyc = 0;
    integer             seed = 32'h94099B78;

    wakeup_sfr_bank i_dut (.mclk(mclk), .rst_b(rst_b), .req(req), .rdata(rdata),
        .indexLoad(indexLoad), .indexLoadEn(indexLoadEn), .sramIndexPointer(sramIndexPointer),
        .speakerOutputPin(speakerOutputPin), .speakerWakeEvent(speakerWakeEvent),
        .watchdogOptionEn(watchdogOptionEn), .watchdogClear(watchdogClear), .wakeCtrl(wakeCtrl),
        .globalInterruptEnable(globalInterruptEnable), .flashAddress(flashAddress),
        .flashByte(flashByte), .flashWriteNibble(flashWriteNibble));
    far_side_model i_far (.pinLevel(pinLevel), .wakeReq(wakeReq), .flashAddress(flashAddress),
        .speakerOutputPin(speakerOutputPin), .speakerWakeEvent(speakerWakeEvent),
        .flashByte(flashByte));

    // ***************************************************************
    // Clock, watcher, timeout and bus tasks
    // ***************************************************************
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Read data lands one edge after the read is taken; compare at the following falling edge
    always @(posedge mclk) rdSeen <= req.rd;
    always @(negedge mclk) begin
        if (rdSeen === 1'b1) begin
            expV = expQ.pop_front();
            `CHK("rdata", expV, rdata)
        end
    end
    // Whole run needs well under 1000 cycles, so 3000 means a hang
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            end_sim();
        end
    end
    // Request stays up until the next call or idle, so back-to-back calls never double-drive
    task automatic op(input logic w, r, input logic [4:0] a, input logic [3:0] d, e);
        if (r) expQ.push_back(e);
        req = '{wr: w, rd: r, addr: a, wdata: d};
        @(negedge mclk);
    endtask
    task automatic idle();
        req = '0;
        @(negedge mclk);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ***************************************************************
    // Scenarios
    // ***************************************************************
    initial begin
        req = '0; indexLoad = '0; indexLoadEn = 1'b0; watchdogOptionEn = 1'b0;
        pinLevel = 1'b0; wakeReq = 1'b0; rst_b = 1'b0;
        repeat (12) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        `CHK("wakeCtrl", 5'h00, wakeCtrl)
        `CHK("gie", 1'b1, globalInterruptEnable)
        op(0, 1, OFF_WAKE_CTRL, 4'h0, CTRL_RESET);
        op(0, 1, OFF_WAKE_STATUS, 4'h0, STATUS_RESET);
        op(0, 1, 5'h14, 4'h0, 4'h0);
        idle();
        done("reset");
        // Every sensitivity code with both enable values; a written 1 must not set the flag
        for (int i = 0; i < 8; i++) begin
            v = {1'b1, i[2:0]};
            op(1, 0, OFF_WAKE_CTRL, v, 4'h0);
            `CHK("sens", v[2:1], wakeCtrl.wakeupSensitivitySelect)
            `CHK("wen", v[0], wakeCtrl.speakerWakeupEnable)
            op(0, 1, OFF_WAKE_CTRL, 4'h0, {1'b0, v[2:0]});
        end
        idle();
        done("control");
        // Pin level needs two edges through the synchroniser; bit 3 writes are ignored
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            pinLevel = i[0];
            repeat (3) idle();
            op(1, 0, OFF_WAKE_STATUS, v, 4'h0);
            `CHK("bzEn", v[2], wakeCtrl.buzzerSpeakerWakeupEnable)
            `CHK("level_detector_enable", v[1], wakeCtrl.levelDetectorEnable)
            `CHK("gie", v[0], globalInterruptEnable)
            op(0, 1, OFF_WAKE_STATUS, 4'h0, {i[0], v[2:0]});
        end
        idle();
        done("status");
        wakeReq = 1'b1;
        repeat (3) idle();
        wakeReq = 1'b0;
        repeat (3) idle();
        op(0, 1, OFF_WAKE_CTRL, 4'h0, 4'hF);
        repeat (4) idle();
        op(0, 1, OFF_WAKE_CTRL, 4'h0, 4'hF);
        op(1, 0, OFF_WAKE_CTRL, 4'h7, 4'h0);
        op(0, 1, OFF_WAKE_CTRL, 4'h0, 4'h7);
        idle();
        done("wakeup");
        // Post-increment writes across the top of the index range, then reads back
        indexLoad = 10'h3FE;
        indexLoadEn = 1'b1;
        idle();
        indexLoadEn = 1'b0;
        for (int i = 0; i < 4; i++) begin
            nib[i] = $random(seed);
            op(1, 0, OFF_SRAM_INC, nib[i], 4'h0);
        end
        `CHK("index", 10'h002, sramIndexPointer)
        indexLoadEn = 1'b1;
        idle();
        indexLoadEn = 1'b0;
        op(0, 1, OFF_SRAM_PORT, 4'h0, nib[0]);
        op(0, 1, OFF_SRAM_PORT, 4'h0, nib[0]);
        `CHK("index", 10'h3FE, sramIndexPointer)
        for (int i = 0; i < 4; i++) op(0, 1, OFF_SRAM_INC, 4'h0, nib[i]);
        idle();
        `CHK("index", 10'h002, sramIndexPointer)
        done("sram");
        // The clear pulse follows the write only while the option enables the watchdog
        for (int k = 1; k >= 0; k--) begin
            watchdogOptionEn = k[0];
            op(1, 0, OFF_WDOG, 4'h5, 4'h0);
            `CHK("wdClear", k[0], watchdogClear)
            idle();
            `CHK("wdClear", 1'b0, watchdogClear)
        end
        done("watchdog");
        // Random address nibbles lowest first, flash nibble read, write nibble staging
        for (int n = 0; n < 2; n++) begin
            for (int i = 0; i < FADDR_NIB; i++) begin
                v = $random(seed);
                fa[4*i+:4] = v;
                op(1, 0, OFF_FADDR0 + 5'(i), v, 4'h0);
            end
            idle();
            `CHK("faddr", fa[18:0], flashAddress)
            op(0, 1, OFF_FADDR4, 4'h0, fa[19:16]);
            op(0, 1, OFF_FDATA, 4'h0, fa[3:0] ^ fa[14:11] ^ 4'hA);
            op(1, 0, OFF_FDATA, ~v, 4'h0);
            idle();
            `CHK("wrNib", ~v, flashWriteNibble)
        end
        done("flash");
        end_sim();
    end
endmodule
